// >>> core/status_event_reporting.v
`timescale 1ns/1ns
`include "status_defs.vh"

//////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Preset sets rise filters, clears others
// - Run events clear on read
// - Run bits 10, 8, 5
// - Run condition live, read-only
// - Bit 7 ORs enabled run events
// - Filters pick latching edges
// - Warning events clear on read
// - Warning bits 10,9,4,2,1,0
// - Warning condition live except latched trip bits 1 and 0, read-only
// - Bit 3 ORs enabled warning events
// - Clear-status wipes events and status
// - After terminator it also flushes replies
// - Bit 5 ORs enabled standard events
// - Standard bits 7,5,4,3,2,0
// - Standard events clear on read
// - Completion flag waits, never blocks
// - Completion query blocks, replies ASCII one
// - Master summary ORs masked status
// - Poll shows and clears request flag
// - Status byte query clears nothing
// - Status byte bits 7 to 2
// - Wait stalls; only device clear aborts
// - Abort and reset clear trigger wait
// - Trips disable output and flag
//////////////////////////////////////////////////////////////////////////

module status_event_reporting (
    input  wire        ref_clk,
    input  wire        srst,
    input  wire        cmd_valid,
    input  wire [4:0]  cmd_code,
    input  wire [15:0] cmd_data,
    input  wire        cmd_after_term,
    output wire        cmd_ready,
    output reg         rsp_valid_reg,
    output reg  [15:0] rsp_data_reg,
    input  wire        rsp_ready,
    input  wire        poll_req,
    output reg         poll_valid_reg,
    output reg  [7:0]  poll_data_reg,
    output reg         service_request_flag_reg,
    input  wire        dev_clear,
    input  wire        ops_pending,
    input  wire        current_limited_flag,
    input  wire        voltage_regulated_flag,
    input  wire        trig_arm,
    input  wire        trig_done,
    input  wire        abort,
    input  wire        loss_of_regulation,
    input  wire        external_shutoff,
    input  wire        thermal_trip,
    input  wire        mains_loss,
    input  wire        high_amp_detect,
    input  wire        high_volt_detect,
    input  wire        prot_clear,
    input  wire        output_on_req,
    output reg         output_on_reg,
    input  wire        syntax_fault,
    input  wire        run_fault,
    input  wire        unit_fault,
    input  wire        readback_fault,
    input  wire        err_queue_nonempty,
    output reg         err_queue_clear_reg,
    output wire [7:0]  summary_byte
);

//////////////////////////////////////////////////////////////////////////
// Command sequencing

localparam [2:0] ST_IDLE = 3'b001;
localparam [2:0] ST_WAI  = 3'b010;
localparam [2:0] ST_OPCQ = 3'b100;

reg  [2:0] state_reg;
reg  [2:0] state_next;

function hit;
    input       take;
    input [4:0] code;
    input [4:0] want;
    begin
        hit = take & (code == want);
    end
endfunction

wire take = cmd_valid & cmd_ready;

wire do_preset    = hit(take, cmd_code, `CMD_PRESET);
wire rd_run_ev    = hit(take, cmd_code, `CMD_RD_RUN_EV);
wire rd_warn_ev   = hit(take, cmd_code, `CMD_RD_WARN_EV);
wire rd_std_ev    = hit(take, cmd_code, `CMD_RD_STD_EV);
wire do_cls       = hit(take, cmd_code, `CMD_CLS);
wire do_opc       = hit(take, cmd_code, `CMD_OPC);
wire do_opc_qry   = hit(take, cmd_code, `CMD_OPC_QRY);
wire do_wai       = hit(take, cmd_code, `CMD_WAI);
wire wr_std_mask  = hit(take, cmd_code, `CMD_WR_STD_MASK);
wire wr_srq_mask  = hit(take, cmd_code, `CMD_WR_SRQ_MASK);
wire wr_run_mask  = hit(take, cmd_code, `CMD_WR_RUN_MASK);
wire wr_run_fall  = hit(take, cmd_code, `CMD_WR_RUN_FALL);
wire wr_run_rise  = hit(take, cmd_code, `CMD_WR_RUN_RISE);
wire wr_warn_mask = hit(take, cmd_code, `CMD_WR_WARN_MASK);
wire wr_warn_fall = hit(take, cmd_code, `CMD_WR_WARN_FALL);
wire wr_warn_rise = hit(take, cmd_code, `CMD_WR_WARN_RISE);

// Reply flush only after a terminator
wire cls_flush = do_cls & cmd_after_term;

assign cmd_ready = state_reg[0];

always @* begin
    state_next = state_reg;
    case (state_reg)
        ST_IDLE: begin
            if (do_wai)
                state_next = ST_WAI;
            else if (do_opc_qry)
                state_next = ST_OPCQ;
        end
        ST_WAI: begin
            // Only device clear or completion ends it
            if (dev_clear || !ops_pending)
                state_next = ST_IDLE;
        end
        ST_OPCQ: begin
            if (dev_clear || !ops_pending)
                state_next = ST_IDLE;
        end
        default: state_next = ST_IDLE;
    endcase
end

always @(posedge ref_clk) begin
    if (srst)
        state_reg <= ST_IDLE;
    else
        state_reg <= state_next;
end

wire opcq_done = state_reg[2] & ~ops_pending & ~dev_clear;

//////////////////////////////////////////////////////////////////////////
// Supply state feeding the condition registers

reg trig_wait_reg;
reg hi_amp_latch_reg;
reg hi_volt_latch_reg;

always @(posedge ref_clk) begin
    if (srst) begin
        trig_wait_reg     <= 1'b0;
        hi_amp_latch_reg  <= 1'b0;
        hi_volt_latch_reg <= 1'b0;
        output_on_reg     <= 1'b0;
    end else begin
        if (abort || trig_done)
            trig_wait_reg <= 1'b0;
        else if (trig_arm)
            trig_wait_reg <= 1'b1;
        // Trips always latch; a clear only works once the cause is gone
        if (high_amp_detect)
            hi_amp_latch_reg <= 1'b1;
        else if (prot_clear)
            hi_amp_latch_reg <= 1'b0;
        if (high_volt_detect)
            hi_volt_latch_reg <= 1'b1;
        else if (prot_clear)
            hi_volt_latch_reg <= 1'b0;
        output_on_reg <= output_on_req & ~high_amp_detect & ~high_volt_detect
                         & ~hi_amp_latch_reg & ~hi_volt_latch_reg;
    end
end

// Live views; only warning bits 1 and 0 show latched trips
reg [15:0] run_condition;
reg [15:0] warning_condition;

always @* begin
    run_condition = 16'h0000;
    run_condition[`RUN_CURR_LIM_BIT]  = current_limited_flag;
    run_condition[`RUN_VOLT_REG_BIT]  = voltage_regulated_flag;
    run_condition[`RUN_TRIG_WAIT_BIT] = trig_wait_reg;
    warning_condition = 16'h0000;
    warning_condition[`WARN_UNREG_BIT]   = loss_of_regulation;
    warning_condition[`WARN_EXT_OFF_BIT] = external_shutoff;
    warning_condition[`WARN_THERMAL_BIT] = thermal_trip;
    warning_condition[`WARN_MAINS_BIT]   = mains_loss;
    warning_condition[`WARN_HI_AMP_BIT]  = hi_amp_latch_reg;
    warning_condition[`WARN_HI_VOLT_BIT] = hi_volt_latch_reg;
end

//////////////////////////////////////////////////////////////////////////
// Run and warning groups

wire [15:0] run_event_latch;
wire [15:0] run_enable_mask;
wire [15:0] run_falling_filter;
wire [15:0] run_rising_filter;
wire        run_summary;
wire [15:0] warning_event_latch;
wire [15:0] warning_enable_mask;
wire [15:0] warning_falling_filter;
wire [15:0] warning_rising_filter;
wire        warning_summary;

transition_group #(
    .WIDTH   (16),
    .DEFINED (`RUN_DEFINED)
) run_group (
    .ref_clk     (ref_clk),
    .srst        (srst),
    .condition   (run_condition),
    .preset      (do_preset),
    .clear_event (rd_run_ev | do_cls),
    .wr_mask     (wr_run_mask),
    .wr_fall     (wr_run_fall),
    .wr_rise     (wr_run_rise),
    .wr_data     (cmd_data),
    .event_reg   (run_event_latch),
    .mask_reg    (run_enable_mask),
    .fall_reg    (run_falling_filter),
    .rise_reg    (run_rising_filter),
    .summary     (run_summary)
);

transition_group #(
    .WIDTH   (16),
    .DEFINED (`WARN_DEFINED)
) warning_group (
    .ref_clk     (ref_clk),
    .srst        (srst),
    .condition   (warning_condition),
    .preset      (do_preset),
    .clear_event (rd_warn_ev | do_cls),
    .wr_mask     (wr_warn_mask),
    .wr_fall     (wr_warn_fall),
    .wr_rise     (wr_warn_rise),
    .wr_data     (cmd_data),
    .event_reg   (warning_event_latch),
    .mask_reg    (warning_enable_mask),
    .fall_reg    (warning_falling_filter),
    .rise_reg    (warning_rising_filter),
    .summary     (warning_summary)
);

//////////////////////////////////////////////////////////////////////////
// Standard events and completion tracking

reg  [7:0] std_event_latch;
reg  [7:0] std_event_mask;
reg  [7:0] service_request_mask;
reg        opc_armed_reg;
reg  [7:0] std_set;

wire opc_fire = opc_armed_reg & ~ops_pending;

always @* begin
    std_set = 8'h00;
    std_set[`STD_SYNTAX_BIT]   = syntax_fault;
    std_set[`STD_RUN_FLT_BIT]  = run_fault;
    std_set[`STD_UNIT_FLT_BIT] = unit_fault;
    std_set[`STD_READBACK_BIT] = readback_fault;
    std_set[`STD_DONE_BIT]     = opc_fire;
end

always @(posedge ref_clk) begin
    if (srst) begin
        std_event_latch      <= `STD_RESET;
        std_event_mask       <= 8'h00;
        service_request_mask <= 8'h00;
        opc_armed_reg        <= 1'b0;
    end else begin
        // New events win over a same-cycle clear
        std_event_latch <= ((rd_std_ev | do_cls) ? 8'h00 : std_event_latch)
                           | std_set;
        if (wr_std_mask)
            std_event_mask <= cmd_data[7:0] & `STD_DEFINED;
        if (wr_srq_mask)
            service_request_mask <= cmd_data[7:0] & `STB_DEFINED;
        // Arming never stalls the command stream
        if (do_cls || opc_fire)
            opc_armed_reg <= 1'b0;
        if (do_opc)
            opc_armed_reg <= 1'b1;
    end
end

//////////////////////////////////////////////////////////////////////////
// Summary byte and service request

reg  [7:0] stb_low;
reg        master_prev_reg;
wire       master_summary;

always @* begin
    stb_low = 8'h00;
    stb_low[`STB_RUN_BIT]   = run_summary;
    stb_low[`STB_STD_BIT]   = |(std_event_latch & std_event_mask);
    stb_low[`STB_REPLY_BIT] = rsp_valid_reg;
    stb_low[`STB_WARN_BIT]  = warning_summary;
    stb_low[`STB_ERR_BIT]   = err_queue_nonempty;
end

// A zero mask blocks every request
assign master_summary = |(stb_low & service_request_mask);

assign summary_byte = stb_low | ({7'h00, master_summary} << `STB_MASTER_BIT);

always @(posedge ref_clk) begin
    if (srst) begin
        master_prev_reg          <= 1'b0;
        service_request_flag_reg <= 1'b0;
        poll_valid_reg           <= 1'b0;
        poll_data_reg            <= 8'h00;
        err_queue_clear_reg      <= 1'b0;
    end else begin
        master_prev_reg     <= master_summary;
        poll_valid_reg      <= poll_req;
        err_queue_clear_reg <= do_cls;
        if (poll_req) begin
            poll_data_reg <= summary_byte;
            poll_data_reg[`STB_MASTER_BIT] <= service_request_flag_reg;
        end
        // A fresh rise wins over a poll clear
        if (master_summary && !master_prev_reg)
            service_request_flag_reg <= 1'b1;
        else if (poll_req || do_cls)
            service_request_flag_reg <= 1'b0;
    end
end

//////////////////////////////////////////////////////////////////////////
// Reply queue, one entry deep

reg        rsp_load;
reg [15:0] rsp_word;

always @* begin
    rsp_load = take;
    rsp_word = 16'h0000;
    if (cmd_code == `CMD_RD_RUN_EV)
        rsp_word = run_event_latch;
    else if (cmd_code == `CMD_RD_RUN_COND)
        rsp_word = run_condition;
    else if (cmd_code == `CMD_RD_RUN_MASK)
        rsp_word = run_enable_mask;
    else if (cmd_code == `CMD_RD_RUN_FALL)
        rsp_word = run_falling_filter;
    else if (cmd_code == `CMD_RD_RUN_RISE)
        rsp_word = run_rising_filter;
    else if (cmd_code == `CMD_RD_WARN_EV)
        rsp_word = warning_event_latch;
    else if (cmd_code == `CMD_RD_WARN_COND)
        rsp_word = warning_condition;
    else if (cmd_code == `CMD_RD_WARN_MASK)
        rsp_word = warning_enable_mask;
    else if (cmd_code == `CMD_RD_WARN_FALL)
        rsp_word = warning_falling_filter;
    else if (cmd_code == `CMD_RD_WARN_RISE)
        rsp_word = warning_rising_filter;
    else if (cmd_code == `CMD_RD_STD_MASK)
        rsp_word = {8'h00, std_event_mask};
    else if (cmd_code == `CMD_RD_STD_EV)
        rsp_word = {8'h00, std_event_latch};
    else if (cmd_code == `CMD_RD_SRQ_MASK)
        rsp_word = {8'h00, service_request_mask};
    else if (cmd_code == `CMD_RD_STB)
        rsp_word = {8'h00, summary_byte};
    else
        rsp_load = 1'b0;
    if (opcq_done) begin
        rsp_load = 1'b1;
        rsp_word = `ASCII_ONE;
    end
end

always @(posedge ref_clk) begin
    if (srst) begin
        rsp_valid_reg <= 1'b0;
        rsp_data_reg  <= 16'h0000;
    end else begin
        // A new reply overwrites an unread one
        if (rsp_load) begin
            rsp_valid_reg <= 1'b1;
            rsp_data_reg  <= rsp_word;
        end else if (cls_flush || (rsp_valid_reg && rsp_ready)) begin
            rsp_valid_reg <= 1'b0;
            rsp_data_reg  <= 16'h0000;
        end
    end
end

endmodule // status_event_reporting

// >>> inc/status_defs.vh
`ifndef STATUS_DEFS_VH
`define STATUS_DEFS_VH

// Command codes on the command port
`define CMD_PRESET        5'h00
`define CMD_RD_RUN_EV     5'h01
`define CMD_RD_RUN_COND   5'h02
`define CMD_WR_RUN_MASK   5'h03
`define CMD_RD_RUN_MASK   5'h04
`define CMD_WR_RUN_FALL   5'h05
`define CMD_RD_RUN_FALL   5'h06
`define CMD_WR_RUN_RISE   5'h07
`define CMD_RD_RUN_RISE   5'h08
`define CMD_RD_WARN_EV    5'h09
`define CMD_RD_WARN_COND  5'h0a
`define CMD_WR_WARN_MASK  5'h0b
`define CMD_RD_WARN_MASK  5'h0c
`define CMD_WR_WARN_FALL  5'h0d
`define CMD_RD_WARN_FALL  5'h0e
`define CMD_WR_WARN_RISE  5'h0f
`define CMD_RD_WARN_RISE  5'h10
`define CMD_CLS           5'h11
`define CMD_WR_STD_MASK   5'h12
`define CMD_RD_STD_MASK   5'h13
`define CMD_RD_STD_EV     5'h14
`define CMD_OPC           5'h15
`define CMD_OPC_QRY       5'h16
`define CMD_WR_SRQ_MASK   5'h17
`define CMD_RD_SRQ_MASK   5'h18
`define CMD_RD_STB        5'h19
`define CMD_WAI           5'h1a

// Run group bit positions
`define RUN_CURR_LIM_BIT  10
`define RUN_VOLT_REG_BIT  8
`define RUN_TRIG_WAIT_BIT 5
`define RUN_DEFINED       16'h0520

// Warning group bit positions
`define WARN_UNREG_BIT    10
`define WARN_EXT_OFF_BIT  9
`define WARN_THERMAL_BIT  4
`define WARN_MAINS_BIT    2
`define WARN_HI_AMP_BIT   1
`define WARN_HI_VOLT_BIT  0
`define WARN_DEFINED      16'h0617

// Standard event bit positions
`define STD_POWERUP_BIT   7
`define STD_SYNTAX_BIT    5
`define STD_RUN_FLT_BIT   4
`define STD_UNIT_FLT_BIT  3
`define STD_READBACK_BIT  2
`define STD_DONE_BIT      0
`define STD_DEFINED       8'hbd
`define STD_RESET         8'h80

// Summary byte bit positions
`define STB_RUN_BIT       7
`define STB_MASTER_BIT    6
`define STB_STD_BIT       5
`define STB_REPLY_BIT     4
`define STB_WARN_BIT      3
`define STB_ERR_BIT       2
`define STB_DEFINED       8'hfc

// Preset and reset values of filters and masks
`define RISE_PRESET       16'h7fff
`define FALL_PRESET       16'h0000
`define MASK_PRESET       16'h0000
`define ASCII_ONE         16'h0031

`endif

// >>> core/transition_group.v
`timescale 1ns/1ns
`include "status_defs.vh"

module transition_group #(
    parameter WIDTH           = 16,
    parameter [15:0] DEFINED  = 16'hffff
) (
    input  wire             ref_clk,
    input  wire             srst,
    input  wire [WIDTH-1:0] condition,
    input  wire             preset,
    input  wire             clear_event,
    input  wire             wr_mask,
    input  wire             wr_fall,
    input  wire             wr_rise,
    input  wire [WIDTH-1:0] wr_data,
    output reg  [WIDTH-1:0] event_reg,
    output reg  [WIDTH-1:0] mask_reg,
    output reg  [WIDTH-1:0] fall_reg,
    output reg  [WIDTH-1:0] rise_reg,
    output wire             summary
);

wire [WIDTH-1:0] defined = DEFINED[WIDTH-1:0];
reg  [WIDTH-1:0] prev_reg;
wire [WIDTH-1:0] edge_hits;
wire [WIDTH-1:0] event_next;

// Filtered edges; both filters set catches any edge
assign edge_hits = ((condition & ~prev_reg & rise_reg)
                  | (~condition & prev_reg & fall_reg)) & defined;
// A new edge wins over a clear in the same cycle
assign event_next = (clear_event ? {WIDTH{1'b0}} : event_reg) | edge_hits;
assign summary = |(event_reg & mask_reg);

always @(posedge ref_clk) begin
    if (srst) begin
        prev_reg  <= {WIDTH{1'b0}};
        event_reg <= {WIDTH{1'b0}};
        mask_reg  <= `MASK_PRESET;
        fall_reg  <= `FALL_PRESET;
        rise_reg  <= `RISE_PRESET & DEFINED;
    end else begin
        prev_reg  <= condition;
        event_reg <= event_next;
        if (preset) begin
            rise_reg <= `RISE_PRESET & DEFINED;
            fall_reg <= `FALL_PRESET;
            mask_reg <= `MASK_PRESET;
        end else begin
            if (wr_mask)
                mask_reg <= wr_data & defined;
            if (wr_fall)
                fall_reg <= wr_data & defined;
            if (wr_rise)
                rise_reg <= wr_data & defined;
        end
    end
end

endmodule // transition_group

// >>> test/status_event_reporting_props.sv
`timescale 1ns/1ns
`include "status_defs.vh"

module status_event_reporting_props (
    input wire logic        ref_clk,
    input wire logic        srst,
    input wire logic        cmd_valid,
    input wire logic [4:0]  cmd_code,
    input wire logic        cmd_after_term,
    input wire logic        cmd_ready,
    input wire logic        rsp_valid_reg,
    input wire logic [15:0] rsp_data_reg,
    input wire logic        poll_req,
    input wire logic [7:0]  poll_data_reg,
    input wire logic        service_request_flag_reg,
    input wire logic        dev_clear,
    input wire logic        ops_pending,
    input wire logic        high_volt_detect,
    input wire logic        output_on_reg,
    input wire logic        err_queue_clear_reg,
    input wire logic [7:0]  summary_byte
);
    default clocking
        @(posedge ref_clk);
    endclocking
    default disable iff (srst);

    wire take = cmd_valid && cmd_ready;

    sequence opc_ask;
        take && cmd_code == `CMD_OPC_QRY && !dev_clear;
    endsequence
    sequence opc_free;
        !ops_pending && !dev_clear;
    endsequence

    reply_bit_a: assert property (rsp_valid_reg == summary_byte[4])
        else $error("reply bit wrong");
    flag_set_a: assert property ($rose(summary_byte[6]) |=> service_request_flag_reg)
        else $error("flag not set");
    flag_hold_a: assert property (!summary_byte[6] && !service_request_flag_reg
        |=> !service_request_flag_reg)
        else $error("stray flag");
    poll_clear_a: assert property (poll_req && service_request_flag_reg && !$rose(summary_byte[6])
        |=> poll_data_reg[6] && !service_request_flag_reg)
        else $error("poll wrong");
    wai_stall_a: assert property (take && cmd_code == `CMD_WAI && ops_pending && !dev_clear
        |=> !cmd_ready)
        else $error("no stall");
    wai_free_a: assert property (!cmd_ready && (dev_clear || !ops_pending)
        |-> ##[1:2] cmd_ready)
        else $error("stall stuck");
    opc_reply_a: assert property (opc_ask ##1 opc_free
        |=> rsp_valid_reg && rsp_data_reg == `ASCII_ONE)
        else $error("no reply");
    cls_pulse_a: assert property (take && cmd_code == `CMD_CLS |=> err_queue_clear_reg)
        else $error("no clear");
    cls_flush_a: assert property (take && cmd_code == `CMD_CLS && cmd_after_term
        |=> !rsp_valid_reg)
        else $error("no flush");
    trip_off_a: assert property (high_volt_detect |=> !output_on_reg)
        else $error("output on");
endmodule // status_event_reporting_props

bind status_event_reporting status_event_reporting_props u_status_event_reporting_props (.*);

// >>> test/host_ctrl_model.sv
`timescale 1ns/1ns

module host_ctrl_model (
    input  wire logic ref_clk,
    input  wire logic srst,
    input  wire logic slow,
    input  wire logic rsp_valid_reg,
    input  wire logic service_request_flag_reg,
    output logic      rsp_ready,
    output logic      poll_req
);
    // Slow mode never reads, so replies stay pending
    always @(posedge ref_clk) begin
        if (srst) begin
            rsp_ready <= 1'b0;
            poll_req  <= 1'b0;
        end else begin
            rsp_ready <= rsp_valid_reg && !rsp_ready && !slow;
            // One poll per request
            poll_req  <= service_request_flag_reg && !poll_req;
        end
    end
endmodule // host_ctrl_model

// >>> test/tb_status_event_reporting.sv
`timescale 1ns/1ns
`include "status_defs.vh"

module tb_status_event_reporting;
    reg         ref_clk;
    reg         srst;
    reg         cmd_valid;
    reg  [4:0]  cmd_code;
    reg  [15:0] cmd_data;
    reg         cmd_after_term;
    reg         slow;
    reg  [10:0] lv;
    reg  [8:0]  pv;
    wire        cmd_ready;
    wire        rsp_valid_reg;
    wire [15:0] rsp_data_reg;
    wire        rsp_ready;
    wire        poll_req;
    wire        poll_valid_reg;
    wire [7:0]  poll_data_reg;
    wire        service_request_flag_reg;
    wire        output_on_reg;
    wire        err_queue_clear_reg;
    wire [7:0]  summary_byte;
    integer     err_total;
    integer     n_checks;
    integer     cycles;
    integer     k;

    status_event_reporting u_status_event_reporting (
        .*, .dev_clear(pv[4]), .ops_pending(lv[8]), .current_limited_flag(lv[7]),
        .voltage_regulated_flag(lv[6]), .trig_arm(pv[0]), .trig_done(pv[1]), .abort(pv[2]),
        .loss_of_regulation(lv[5]), .external_shutoff(lv[4]), .thermal_trip(lv[3]),
        .mains_loss(lv[2]), .high_amp_detect(lv[1]), .high_volt_detect(lv[0]),
        .prot_clear(pv[3]), .output_on_req(lv[10]), .syntax_fault(pv[5]), .run_fault(pv[6]),
        .unit_fault(pv[7]), .readback_fault(pv[8]), .err_queue_nonempty(lv[9])
    );

    host_ctrl_model u_host_ctrl_model (.*);

    ////////////////////////////////////////////////////////////////////////////////
    task chk(input [15:0] got, input [15:0] exp);
        begin
            n_checks = n_checks + 1;
            if (got !== exp) begin
                err_total = err_total + 1;
                $display("unexpected at %0t: got %h want %h", $time, got, exp);
            end
        end
    endtask

    // Ready is sampled mid-cycle, once settled
    task cmd(input [4:0] c, input [15:0] d);
        begin
            cmd_code <= c;
            cmd_data <= d;
            cmd_valid <= 1'b1;
            @(negedge ref_clk);
            while (cmd_ready !== 1'b1) @(negedge ref_clk);
            @(posedge ref_clk);
            cmd_valid <= 1'b0;
            @(posedge ref_clk);
        end
    endtask

    task q(input [4:0] c, input [15:0] e);
        begin
            cmd(c, 16'h0000);
            @(negedge ref_clk);
            chk(rsp_data_reg, e);
            @(posedge ref_clk);
        end
    endtask

    task pulse(input [8:0] m);
        begin
            pv <= m;
            @(posedge ref_clk);
            pv <= 9'h000;
            repeat (3) @(posedge ref_clk);
        end
    endtask

    task t_preset;
        begin
            q(`CMD_RD_WARN_RISE, 16'h0617);
            q(`CMD_RD_STD_EV, 16'h0080);
            q(`CMD_RD_STD_EV, 16'h0000);
            cmd(`CMD_WR_RUN_MASK, 16'hffff);
            cmd(`CMD_WR_WARN_FALL, 16'hffff);
            cmd(`CMD_WR_RUN_RISE, 16'h0000);
            q(`CMD_RD_RUN_MASK, 16'h0520);
            cmd(`CMD_PRESET, 16'h0000);
            q(`CMD_RD_RUN_RISE, 16'h0520);
            q(`CMD_RD_RUN_MASK, 16'h0000);
            q(`CMD_RD_WARN_FALL, 16'h0000);
        end
    endtask

    task t_run;
        begin
            cmd(`CMD_WR_RUN_RISE, 16'h0100);
            cmd(`CMD_WR_RUN_FALL, 16'h0400);
            cmd(`CMD_WR_RUN_MASK, 16'h0400);
            lv[7:6] <= 2'b11;
            repeat (3) @(posedge ref_clk);
            q(`CMD_RD_RUN_COND, 16'h0500);
            q(`CMD_RD_RUN_EV, 16'h0100);
            lv[7:6] <= 2'b00;
            repeat (3) @(posedge ref_clk);
            @(negedge ref_clk);
            chk(summary_byte[7], 16'h0001);
            @(posedge ref_clk);
            q(`CMD_RD_RUN_EV, 16'h0400);
            q(`CMD_RD_RUN_EV, 16'h0000);
            chk(summary_byte[7], 16'h0000);
            pulse(9'h001);
            q(`CMD_RD_RUN_COND, 16'h0020);
            pulse(9'h004);
            q(`CMD_RD_RUN_COND, 16'h0000);
        end
    endtask

    task t_warn;
        begin
            lv[10] <= 1'b1;
            lv[5:0] <= 6'h3f;
            repeat (3) @(posedge ref_clk);
            q(`CMD_RD_WARN_COND, 16'h0617);
            chk(output_on_reg, 16'h0000);
            lv[5:0] <= 6'h00;
            repeat (3) @(posedge ref_clk);
            q(`CMD_RD_WARN_COND, 16'h0003);
            pulse(9'h008);
            q(`CMD_RD_WARN_COND, 16'h0000);
            chk(output_on_reg, 16'h0001);
            cmd(`CMD_WR_WARN_MASK, 16'h0010);
            chk(summary_byte[3], 16'h0001);
            q(`CMD_RD_WARN_EV, 16'h0617);
            chk(summary_byte[3], 16'h0000);
            q(`CMD_RD_WARN_EV, 16'h0000);
        end
    endtask

    task t_std;
        begin
            cmd(`CMD_WR_STD_MASK, 16'h00ff);
            q(`CMD_RD_STD_MASK, 16'h00bd);
            cmd(`CMD_WR_STD_MASK, 16'h0001);
            lv[8] <= 1'b1;
            cmd(`CMD_OPC, 16'h0000);
            pulse(9'h1e0);
            @(negedge ref_clk);
            chk(cmd_ready, 16'h0001);
            chk(summary_byte[5], 16'h0000);
            @(posedge ref_clk);
            lv[8] <= 1'b0;
            repeat (3) @(posedge ref_clk);
            chk(summary_byte[5], 16'h0001);
            q(`CMD_RD_STD_EV, 16'h003d);
            chk(summary_byte[5], 16'h0000);
        end
    endtask

    task t_srq;
        begin
            lv[9] <= 1'b1;
            cmd(`CMD_WR_STD_MASK, 16'h0010);
            pulse(9'h040);
            chk(service_request_flag_reg, 16'h0000);
            cmd(`CMD_WR_SRQ_MASK, 16'h0020);
            k = 0;
            while (poll_valid_reg !== 1'b1 && k < 20) begin
                @(negedge ref_clk);
                k = k + 1;
            end
            chk(poll_data_reg, 16'h0064);
            chk(service_request_flag_reg, 16'h0000);
            chk(summary_byte[6], 16'h0001);
            @(posedge ref_clk);
            cmd(`CMD_RD_STB, 16'h0000);
            chk(rsp_data_reg & 16'hffef, 16'h0064);
            cmd(`CMD_RD_STB, 16'h0000);
            chk(rsp_data_reg & 16'hffef, 16'h0064);
        end
    endtask

    task t_cls;
        begin
            slow <= 1'b1;
            cmd(`CMD_RD_STB, 16'h0000);
            cmd(`CMD_CLS, 16'h0000);
            chk(rsp_valid_reg, 16'h0001);
            cmd_after_term <= 1'b1;
            cmd(`CMD_CLS, 16'h0000);
            cmd_after_term <= 1'b0;
            slow <= 1'b0;
            chk(rsp_valid_reg, 16'h0000);
            chk(summary_byte & 8'hfb, 16'h0000);
            q(`CMD_RD_STD_EV, 16'h0000);
        end
    endtask

    task t_wait;
        begin
            lv[8] <= 1'b1;
            cmd(`CMD_WAI, 16'h0000);
            repeat (4) @(posedge ref_clk);
            chk(cmd_ready, 16'h0000);
            pulse(9'h010);
            chk(cmd_ready, 16'h0001);
            cmd(`CMD_OPC_QRY, 16'h0000);
            repeat (4) @(posedge ref_clk);
            chk(rsp_valid_reg, 16'h0000);
            lv[8] <= 1'b0;
            k = 0;
            while (rsp_valid_reg !== 1'b1 && k < 20) begin
                @(negedge ref_clk);
                k = k + 1;
            end
            chk(rsp_data_reg, 16'h0031);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task report_and_stop;
        begin
            if (err_total == 0 && n_checks > 0) begin
                $display("Run complete: PASS");
            end else begin
                $display("Run complete: FAIL");
            end
            $finish;
        end
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    // The whole sequence needs a few hundred cycles
    always @(posedge ref_clk) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            err_total = err_total + 1;
            report_and_stop;
        end
    end

    initial begin
        srst = 1'b1;
        cmd_valid = 1'b0;
        cmd_code = 5'h00;
        cmd_data = 16'h0000;
        cmd_after_term = 1'b0;
        slow = 1'b0;
        lv = 11'h000;
        pv = 9'h000;
        err_total = 0;
        n_checks = 0;
        cycles = 0;
        repeat (5) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        t_preset;
        t_run;
        t_warn;
        t_std;
        t_srq;
        t_cls;
        t_wait;
        report_and_stop;
    end
endmodule // tb_status_event_reporting
